// ---- testbench/acp_conv_model.sv ----
`default_nettype none
module acp_conv_model #(
    parameter int DELAY = 10,
    parameter int RES_W = 12
) (
    input  wire logic             clk_sys,
    input  wire logic             sys_rst,
    input  wire logic             conv_start,
    output logic                  conv_done,
    output logic [RES_W-1:0]      conv_data
);
    timeunit 1ns;
    timeprecision 1ns;
    // ========================================================
    // Converter: each start yields one result after a fixed delay.
    int               left_q;
    logic [RES_W-1:0] next_q;

    initial begin
        conv_done = 1'b0;
        conv_data = '0;
        left_q    = 0;
        next_q    = RES_W'(12'h5A0);
    end

    // A result appears with its done pulse and holds until the next countdown; while
    // counting down the bus shows the inverse so that a read taken too early cannot match.
    always @(posedge clk_sys) begin
        conv_done <= 1'b0;
        if (sys_rst) begin
            left_q <= 0;
        end else if (conv_start) begin
            left_q <= DELAY;
        end else if (left_q == 1) begin
            left_q    <= 0;
            conv_done <= 1'b1;
            conv_data <= next_q;
            next_q    <= next_q + 1'b1;
        end else if (left_q > 1) begin
            left_q    <= left_q - 1;
            conv_data <= ~next_q;
        end
    end
endmodule : acp_conv_model
`default_nettype wire

// ---- testbench/tb_top.sv ----
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    // ========================================================
    // Design, converter model and bus drivers.
    logic        clk_sys = 1'b0;
    logic        sys_rst = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic        ext_pin = 1'b1;
    logic        trig = 1'b0;
    logic        conv_done;
    logic [11:0] conv_data;
    logic        conv_start;
    logic        master_out;
    logic        eoc_irq;
    logic        ext_int_req;
    logic        acq_active;
    logic        master_low = 1'b0;
    int          num_errors = 0;
    int          compares = 0;

    always #12.5 clk_sys = ~clk_sys;
    always @(negedge clk_sys) if (master_out === 1'b0) master_low = 1'b1;

    acp_pacer acp_pacer_inst (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .ext_conv_clock_pin(ext_pin), .trigger_gate_input(trig), .conv_done(conv_done),
        .conv_data(conv_data), .conv_start(conv_start), .master_pacer_output(master_out),
        .eoc_irq(eoc_irq), .ext_int_req(ext_int_req), .acq_active(acq_active)
    );
    acp_conv_model acp_conv_model_inst (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .conv_start(conv_start),
        .conv_done(conv_done), .conv_data(conv_data)
    );

    // ========================================================
    // Shared tasks.
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        @(negedge clk_sys);
        d = reg_rdata;
    endtask : rd

    // Counts cycles until the next start pulse, giving up after max.
    task automatic wait_start(input int max, output int n);
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (conv_start !== 1'b1 && n < max);
    endtask : wait_start

    task automatic no_start(input int cycles, input string what);
        int hits;
        hits = 0;
        repeat (cycles) begin
            @(negedge clk_sys);
            if (conv_start !== 1'b0) hits++;
        end
        check(what, 32'h0, 32'(hits));
    endtask : no_start

    task automatic ctrl_start(input logic [31:0] ctrl);
        wr(acp_pkg::OFF_CTRL, ctrl);
        wr(acp_pkg::OFF_CMD, 32'h1);
    endtask : ctrl_start

    task automatic stop_all();
        wr(acp_pkg::OFF_CMD, 32'h2);
        repeat (20) @(posedge clk_sys);
        trig    <= 1'b0;
        ext_pin <= 1'b1;
        repeat (4) @(posedge clk_sys);
    endtask : stop_all

    // ========================================================
    // Scenarios.
    task automatic t_reset();
        logic [31:0] d;
        rd(acp_pkg::OFF_CTRL, d);
        check("ctrl reset", 32'h0, d);
        rd(acp_pkg::OFF_DIV1, d);
        check("div1 reset", 32'h19, d);
        rd(acp_pkg::OFF_STAT, d);
        check("stat done", 32'h1, 32'(d[acp_pkg::SB_DONE]));
        rd(8'hFC, d);
        check("unmapped read", 32'h0, d);
        $display("test reset done");
    endtask : t_reset

    task automatic t_software();
        logic [31:0] d;
        int n;
        wr(acp_pkg::OFF_CTRL, 32'h1 << acp_pkg::CB_EOCIE);
        wr(acp_pkg::OFF_CMD, 32'h4);
        wait_start(4, n);
        check("sw start", 32'h1, 32'(conv_start));
        rd(acp_pkg::OFF_STAT, d);
        check("busy done", 32'h0, 32'(d[acp_pkg::SB_DONE]));
        repeat (20) @(posedge clk_sys);
        rd(acp_pkg::OFF_STAT, d);
        check("stat ready", 32'h3, 32'(d[1:0]));
        check("eoc irq set", 32'h1, 32'(eoc_irq));
        rd(acp_pkg::OFF_DATA, d);
        check("data", 32'h5A0, d);
        rd(acp_pkg::OFF_STAT, d);
        check("ready cleared", 32'h0, 32'(d[acp_pkg::SB_READY]));
        check("eoc irq clear", 32'h0, 32'(eoc_irq));
        $display("test software done");
    endtask : t_software

    task automatic t_pacer(input logic casc, input int exp_gap);
        int n;
        wr(acp_pkg::OFF_DIV1, 32'h2);
        wr(acp_pkg::OFF_DIV2, 32'h3);
        ctrl_start(32'(acp_pkg::SRC_INT) | (32'(casc) << acp_pkg::CB_CASC)
                   | (32'(casc) << acp_pkg::CB_MASTER));
        wait_start(3, n);
        check("pacer first", 32'h1, 32'(conv_start));
        master_low = 1'b0;
        wait_start(exp_gap + 10, n);
        check("pacer gap", 32'(exp_gap), 32'(n));
        wait_start(exp_gap + 10, n);
        check("pacer gap two", 32'(exp_gap), 32'(n));
        check("master pulse", 32'(casc), 32'(master_low));
        stop_all();
        $display("test pacer cascade=%0d done", casc);
    endtask : t_pacer

    task automatic t_external();
        int n;
        wr(acp_pkg::OFF_CTRL, 32'h1 << acp_pkg::CB_XINTEN);
        repeat (6) @(posedge clk_sys);
        check("pin irq sw", 32'h1, 32'(ext_int_req));
        ctrl_start(32'(acp_pkg::SRC_EXT) | (32'h1 << acp_pkg::CB_XINTEN));
        no_start(20, "ext armed idle");
        check("pin irq ext", 32'h0, 32'(ext_int_req));
        @(posedge clk_sys) ext_pin <= 1'b0;
        wait_start(8, n);
        check("ext fall start", 32'h1, 32'(conv_start));
        no_start(60, "single start per edge");
        @(posedge clk_sys) ext_pin <= 1'b1;
        // Falls are kept at least 25 us apart, the fastest the converter takes.
        no_start(1000, "rising edge ignored");
        @(posedge clk_sys) ext_pin <= 1'b0;
        wait_start(8, n);
        check("ext second fall", 32'h1, 32'(conv_start));
        stop_all();
        $display("test external done");
    endtask : t_external

    task automatic t_trigger(input logic [1:0] src);
        int n;
        ctrl_start(32'(src) | (32'h1 << acp_pkg::CB_HWTRIG));
        no_start(30, "wait for trigger");
        check("active waiting", 32'h1, 32'(acq_active));
        @(posedge clk_sys) trig <= 1'b1;
        if (src == acp_pkg::SRC_INT) begin
            wait_start(6, n);
            check("trigger start", 32'h1, 32'(conv_start));
        end else begin
            no_start(30, "trigger only arms");
            @(posedge clk_sys) ext_pin <= 1'b0;
            wait_start(8, n);
            check("armed ext start", 32'h1, 32'(conv_start));
        end
        stop_all();
        $display("test trigger src=%0d done", src);
    endtask : t_trigger

    task automatic t_gate();
        int n;
        wr(acp_pkg::OFF_DIV1, 32'h2);
        ctrl_start(32'(acp_pkg::SRC_INT) | (32'h1 << acp_pkg::CB_GATE));
        no_start(30, "gate low at start");
        @(posedge clk_sys) trig <= 1'b1;
        wait_start(6, n);
        check("gate rise start", 32'h1, 32'(conv_start));
        wait_start(90, n);
        check("gated gap", 32'h50, 32'(n));
        @(posedge clk_sys) trig <= 1'b0;
        no_start(200, "gate low holds");
        @(posedge clk_sys) trig <= 1'b1;
        wait_start(6, n);
        check("gate realign", 32'h1, 32'(conv_start));
        wait_start(90, n);
        check("realigned gap", 32'h50, 32'(n));
        stop_all();
        $display("test gate done");
    endtask : t_gate

    task automatic t_ext_gate();
        int n;
        ctrl_start(32'(acp_pkg::SRC_EXT) | (32'h1 << acp_pkg::CB_GATE));
        @(posedge clk_sys) ext_pin <= 1'b0;
        no_start(1000, "ext gated low");
        @(posedge clk_sys) begin
            ext_pin <= 1'b1;
            trig    <= 1'b1;
        end
        no_start(30, "gate rise no start");
        @(posedge clk_sys) ext_pin <= 1'b0;
        wait_start(8, n);
        check("ext gated start", 32'h1, 32'(conv_start));
        stop_all();
        $display("test external gate done");
    endtask : t_ext_gate

    // ========================================================
    // Run and verdict.
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (4) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_reset();
        t_software();
        t_pacer(1'b0, 2 * acp_pkg::TB_CYC);
        t_pacer(1'b1, 6 * acp_pkg::TB_CYC);
        t_external();
        t_trigger(acp_pkg::SRC_INT);
        t_trigger(acp_pkg::SRC_EXT);
        t_gate();
        t_ext_gate();
        report_and_stop();
    end

    // The whole sequence needs about 3500 cycles; allow ample margin.
    initial begin
        #500000;
        num_errors++;
        $display("[FAIL] watchdog expected finish seen timeout");
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire

// ---- verilog/acp_down_counter.sv ----
`default_nettype none
module acp_down_counter #(
    parameter int W = 16
) (
    input  wire logic         clk_sys,
    input  wire logic         sys_rst,
    input  wire logic         load,
    input  wire logic         en,
    input  wire logic [W-1:0] load_val,
    output logic [W-1:0]      cnt,
    output logic              tc
);
    // A load value of zero stands for 2**W counts.
    assign tc = en && (cnt == W'(1));

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cnt <= '0;
        end else if (load || tc) begin
            cnt <= load_val;
        end else if (en) begin
            cnt <= cnt - W'(1);
        end
    end
endmodule : acp_down_counter
`default_nettype wire

// ---- verilog/acp_pacer.sv ----
`default_nettype none
// How it works
// - Completion status readable before result is used.
// - Reset selects software conversion source.
// - Pacer start converts at once, then per expiry.
// - Pacer counts one microsecond ticks.
// - Normal mode: stage one expiry converts.
// - Cascade: stage one reloads, stage two decrements.
// - Cascade converts only when both stages expire.
// - External clock: convert on each falling edge.
// - External clock pin raises no interrupt while it is the conversion source.
// - Master board drives stage two output pin.
// - Software trigger starts conversions immediately.
// - Hardware trigger is rising trigger input edge.
// - Pacer idles until trigger, then converts.
// - Trigger arms; next external falling edge converts.
// - Gate high allows conversions, low suppresses.
// - Gate and trigger exclusive; low gate waits.
// - Gate never stops external clock alignment.
// - Gate low halts pacer; rise reloads it.
// - Results by port; end-of-conversion interrupt enable.
module acp_pacer #(
    parameter int CNT_W = 16,
    parameter int RES_W = 12
) (
    input  wire logic                       clk_sys,
    input  wire logic                       sys_rst,
    input  wire logic [acp_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [acp_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic [acp_pkg::DATA_W-1:0]      reg_rdata,
    input  wire logic                       ext_conv_clock_pin,
    input  wire logic                       trigger_gate_input,
    input  wire logic                       conv_done,
    input  wire logic [RES_W-1:0]           conv_data,
    output logic                            conv_start,
    output logic                            master_pacer_output,
    output logic                            eoc_irq,
    output logic                            ext_int_req,
    output logic                            acq_active
);
    // ========================================================
    // Elaboration checks.
    if (CNT_W < 2 || CNT_W > 16) begin : g_bad_cnt
        $error("CNT_W must lie between 2 and 16");
    end
    if (RES_W < 1 || RES_W > 32) begin : g_bad_res
        $error("RES_W must lie between 1 and 32");
    end

    // ========================================================
    // Declarations.
    logic [acp_pkg::CTRL_W-1:0] ctrl_q;
    logic [CNT_W-1:0]           div1_q;
    logic [CNT_W-1:0]           div2_q;
    logic [RES_W-1:0]           data_q;
    logic                       busy_q;
    logic                       ready_q;
    logic                       conv_q;
    logic                       master_q;
    logic [acp_pkg::DATA_W-1:0] rdata_q;
    logic [acp_pkg::PRE_W-1:0]  pre_q;
    acp_pkg::acp_state_t        state_q;

    logic [1:0]       src;
    logic             casc;
    logic             hw_trig;
    logic             gate_en;
    logic             wr_cmd;
    logic             cmd_start;
    logic             cmd_stop;
    logic             cmd_conv;
    logic             rd_data;
    logic             xc_lvl;
    logic             xc_fall;
    logic             tg_lvl;
    logic             tg_rise;
    logic             gate_ok;
    logic             gate_rise;
    logic             start_evt;
    logic             tb_tick;
    logic             cnt_run;
    logic [CNT_W-1:0] s1_cnt;
    logic             s1_tc;
    logic             s2_tc;
    logic             stage_two_evt;
    logic             pace_conv;

    // ========================================================
    // Field decode.
    assign src     = ctrl_q[acp_pkg::CB_SRC +: 2];
    assign casc    = ctrl_q[acp_pkg::CB_CASC];
    assign hw_trig = ctrl_q[acp_pkg::CB_HWTRIG];
    // A hardware trigger overrides the gate, so the two never act together.
    assign gate_en = ctrl_q[acp_pkg::CB_GATE] && !hw_trig;

    assign wr_cmd    = reg_wr && (reg_addr == acp_pkg::OFF_CMD);
    assign cmd_start = wr_cmd && reg_wdata[acp_pkg::CMD_START];
    assign cmd_stop  = wr_cmd && reg_wdata[acp_pkg::CMD_STOP];
    assign cmd_conv  = wr_cmd && reg_wdata[acp_pkg::CMD_CONV];
    assign rd_data   = reg_rd && (reg_addr == acp_pkg::OFF_DATA);

    // ========================================================
    // Pin synchronisers.
    acp_sync_edge u_xclk (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .pin_in  (ext_conv_clock_pin),
        .lvl     (xc_lvl),
        .rise    (),
        .fall    (xc_fall)
    );

    acp_sync_edge u_trig (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .pin_in  (trigger_gate_input),
        .lvl     (tg_lvl),
        .rise    (tg_rise),
        .fall    ()
    );

    assign gate_ok   = !gate_en || tg_lvl;
    assign gate_rise = gate_en && tg_rise && (state_q == acp_pkg::ACP_RUN);

    // ========================================================
    // Register writes.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ctrl_q <= acp_pkg::CTRL_RST;
            div1_q <= CNT_W'(acp_pkg::DIV_RST);
            div2_q <= CNT_W'(acp_pkg::DIV_RST);
        end else if (reg_wr) begin
            if (reg_addr == acp_pkg::OFF_CTRL) begin
                ctrl_q <= reg_wdata[acp_pkg::CTRL_W-1:0];
            end
            if (reg_addr == acp_pkg::OFF_DIV1) begin
                div1_q <= reg_wdata[CNT_W-1:0];
            end
            if (reg_addr == acp_pkg::OFF_DIV2) begin
                div2_q <= reg_wdata[CNT_W-1:0];
            end
        end
    end

    // ========================================================
    // Acquisition sequencing.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_q <= acp_pkg::ACP_IDLE;
        end else if (cmd_stop) begin
            state_q <= acp_pkg::ACP_IDLE;
        end else if (cmd_start && src != acp_pkg::SRC_SW) begin
            if (hw_trig) begin
                state_q <= acp_pkg::ACP_WAIT;
            end else begin
                state_q <= acp_pkg::ACP_RUN;
            end
        end else begin
            unique case (state_q)
                acp_pkg::ACP_IDLE: begin
                    state_q <= acp_pkg::ACP_IDLE;
                end
                acp_pkg::ACP_WAIT: begin
                    if (tg_rise) begin
                        state_q <= acp_pkg::ACP_RUN;
                    end
                end
                acp_pkg::ACP_RUN: begin
                    state_q <= acp_pkg::ACP_RUN;
                end
                default: begin
                    state_q <= acp_pkg::ACP_IDLE;
                end
            endcase
        end
    end

    // Every moment that (re)starts the pacer: start, trigger edge, gate edge.
    always_comb begin
        start_evt = 1'b0;
        if (src == acp_pkg::SRC_INT && !cmd_stop) begin
            if (cmd_start && !hw_trig) begin
                start_evt = gate_ok;
            end else if (state_q == acp_pkg::ACP_WAIT && tg_rise && !cmd_start) begin
                start_evt = 1'b1;
            end else if (gate_rise && !cmd_start) begin
                start_evt = 1'b1;
            end
        end
    end

    // ========================================================
    // One microsecond time base, realigned on each start so the first
    // interval is whole.
    assign tb_tick = (pre_q == acp_pkg::PRE_W'(acp_pkg::TB_CYC - 1));

    always_ff @(posedge clk_sys) begin
        if (sys_rst || start_evt || tb_tick) begin
            pre_q <= '0;
        end else begin
            pre_q <= pre_q + acp_pkg::PRE_W'(1);
        end
    end

    // Counters only run in the pacer source while the gate allows.
    assign cnt_run = (state_q == acp_pkg::ACP_RUN) && (src == acp_pkg::SRC_INT)
                     && gate_ok && tb_tick && !start_evt;

    acp_down_counter #(.W(CNT_W)) u_stage_one (
        .clk_sys  (clk_sys),
        .sys_rst  (sys_rst),
        .load     (start_evt),
        .en       (cnt_run),
        .load_val (div1_q),
        .cnt      (s1_cnt),
        .tc       (s1_tc)
    );

    acp_down_counter #(.W(CNT_W)) u_stage_two (
        .clk_sys  (clk_sys),
        .sys_rst  (sys_rst),
        .load     (start_evt),
        .en       (s1_tc && casc),
        .load_val (div2_q),
        .cnt      (),
        .tc       (s2_tc)
    );

    assign stage_two_evt = casc ? s2_tc : s1_tc;

    // ========================================================
    // Conversion requests from every source.
    always_comb begin
        pace_conv = 1'b0;
        if (start_evt) begin
            pace_conv = 1'b1;
        end else if (src == acp_pkg::SRC_INT) begin
            pace_conv = stage_two_evt;
        end else if (src == acp_pkg::SRC_EXT && state_q == acp_pkg::ACP_RUN) begin
            // The clock is never held back; the gate only masks edges.
            pace_conv = xc_fall && gate_ok;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            conv_q <= 1'b0;
        end else begin
            conv_q <= pace_conv || (cmd_conv && src == acp_pkg::SRC_SW);
        end
    end

    // Busy covers the full conversion; a status read while busy shows done low.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            busy_q <= 1'b0;
        end else if (conv_q) begin
            busy_q <= 1'b1;
        end else if (conv_done) begin
            busy_q <= 1'b0;
        end
    end

    // New data wins over a clearing read in the same cycle.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            data_q  <= '0;
            ready_q <= 1'b0;
        end else if (conv_done) begin
            data_q  <= conv_data;
            ready_q <= 1'b1;
        end else if (rd_data) begin
            ready_q <= 1'b0;
        end
    end

    // ========================================================
    // Master output: a low pulse of one microsecond per stage two expiry.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            master_q <= 1'b1;
        end else if (ctrl_q[acp_pkg::CB_MASTER] && stage_two_evt) begin
            master_q <= 1'b0;
        end else if (tb_tick) begin
            master_q <= 1'b1;
        end
    end

    // ========================================================
    // Read port.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rdata_q <= '0;
        end else if (reg_rd) begin
            unique case (reg_addr)
                acp_pkg::OFF_CTRL: rdata_q <= 32'(ctrl_q);
                // A conversion requested last cycle already counts as busy, so a
                // poll right behind the command can never see a stale done.
                acp_pkg::OFF_STAT: rdata_q <= {28'h0000000,
                                              state_q == acp_pkg::ACP_WAIT,
                                              state_q == acp_pkg::ACP_RUN,
                                              ready_q, !(busy_q || conv_q)};
                acp_pkg::OFF_DIV1: rdata_q <= 32'(div1_q);
                acp_pkg::OFF_DIV2: rdata_q <= 32'(div2_q);
                acp_pkg::OFF_DATA: rdata_q <= 32'(data_q);
                default:           rdata_q <= '0;
            endcase
        end else begin
            rdata_q <= '0;
        end
    end

    assign reg_rdata           = rdata_q;
    assign conv_start          = conv_q;
    assign master_pacer_output = master_q;
    assign acq_active          = (state_q != acp_pkg::ACP_IDLE);
    assign eoc_irq             = ctrl_q[acp_pkg::CB_EOCIE] && ready_q;
    assign ext_int_req         = ctrl_q[acp_pkg::CB_XINTEN] && xc_lvl
                                 && (src != acp_pkg::SRC_EXT);

    // ========================================================
    // Assertions.
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    AST_SW_DEFAULT: assert property ($past(sys_rst) |-> src == acp_pkg::SRC_SW)
        else $error("source not software after reset");
    AST_BUSY: assert property (conv_q |=> busy_q && (!$past(reg_rd)
        || $past(reg_addr) != acp_pkg::OFF_STAT || !rdata_q[acp_pkg::SB_DONE]))
        else $error("busy not shown after conversion start");
    AST_START_NOW: assert property (cmd_start && !cmd_stop && !hw_trig
        && !gate_en && src == acp_pkg::SRC_INT |=> conv_start)
        else $error("pacer start did not convert at once");
    AST_TB_TICK: assert property (tb_tick |=> !tb_tick [*8])
        else $error("time base ticks too fast");
    AST_CASC: assert property (casc && s1_tc && !s2_tc && !start_evt
        |-> !pace_conv)
        else $error("cascade converted on stage one alone");
    AST_RELOAD: assert property (s1_tc && !start_evt |=> s1_cnt == $past(div1_q))
        else $error("stage one did not reload");
    AST_EXT_FALL: assert property (src == acp_pkg::SRC_EXT
        && state_q == acp_pkg::ACP_RUN && xc_fall && gate_ok && !cmd_stop |=> conv_start)
        else $error("external falling edge missed");
    AST_WAIT_IDLE: assert property (state_q == acp_pkg::ACP_WAIT && !tg_rise
        && !cmd_start |-> !pace_conv)
        else $error("conversion before trigger");
    AST_GATE_LOW: assert property (gate_en && !tg_lvl |-> !pace_conv)
        else $error("conversion while gate low");
    AST_XINT: assert property (src == acp_pkg::SRC_EXT |-> !ext_int_req)
        else $error("external clock pin raised interrupt");
    AST_MASTER: assert property (ctrl_q[acp_pkg::CB_MASTER] && stage_two_evt
        |=> !master_pacer_output)
        else $error("master output missed expiry");
    AST_EOC: assert property (ctrl_q[acp_pkg::CB_EOCIE] && conv_done
        && !(reg_wr && reg_addr == acp_pkg::OFF_CTRL) |=> eoc_irq)
        else $error("end of conversion not signalled");
endmodule : acp_pacer
`default_nettype wire

// ---- verilog/acp_pkg.sv ----
`default_nettype none
package acp_pkg;
    // ========================================================
    // Register bus.
    localparam int          ADDR_W     = 8;
    localparam int          DATA_W     = 32;
    localparam logic [7:0]  OFF_CTRL   = 8'h00;
    localparam logic [7:0]  OFF_STAT   = 8'h04;
    localparam logic [7:0]  OFF_DIV1   = 8'h08;
    localparam logic [7:0]  OFF_DIV2   = 8'h0C;
    localparam logic [7:0]  OFF_CMD    = 8'h10;
    localparam logic [7:0]  OFF_DATA   = 8'h14;
    // ========================================================
    // Control fields.
    localparam int          CTRL_W     = 8;
    localparam int          CB_SRC     = 0;
    localparam int          CB_CASC    = 2;
    localparam int          CB_HWTRIG  = 3;
    localparam int          CB_GATE    = 4;
    localparam int          CB_EOCIE   = 5;
    localparam int          CB_MASTER  = 6;
    localparam int          CB_XINTEN  = 7;
    localparam logic [7:0]  CTRL_RST   = 8'h00;
    localparam logic [1:0]  SRC_SW     = 2'h0;
    localparam logic [1:0]  SRC_INT    = 2'h1;
    localparam logic [1:0]  SRC_EXT    = 2'h2;
    // Command and status bits.
    localparam int          CMD_START  = 0;
    localparam int          CMD_STOP   = 1;
    localparam int          CMD_CONV   = 2;
    localparam int          SB_DONE    = 0;
    localparam int          SB_READY   = 1;
    localparam int          SB_RUN     = 2;
    localparam int          SB_WAIT    = 3;
    localparam logic [15:0] DIV_RST    = 16'h0019;
    // ========================================================
    // Timing.
    localparam int          CLK_NS     = 25;
    localparam int          TB_NS      = 1000;
    localparam int          TB_CYC     = TB_NS / CLK_NS;
    localparam int          PRE_W      = 6;
    typedef enum logic [1:0] {
        ACP_IDLE = 2'b00,
        ACP_WAIT = 2'b01,
        ACP_RUN  = 2'b11
    } acp_state_t;
endpackage : acp_pkg
`default_nettype wire

// ---- verilog/acp_sync_edge.sv ----
`default_nettype none
module acp_sync_edge (
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    input  wire logic pin_in,
    output logic      lvl,
    output logic      rise,
    output logic      fall
);
    logic s1_q;
    logic s2_q;
    logic prev_q;

    // Edges are taken only from the second stage, so one pin edge is one pulse.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s1_q   <= 1'b0;
            s2_q   <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            s1_q   <= pin_in;
            s2_q   <= s1_q;
            prev_q <= s2_q;
        end
    end

    assign lvl  = s2_q;
    assign rise = s2_q & ~prev_q;
    assign fall = ~s2_q & prev_q;
endmodule : acp_sync_edge
`default_nettype wire
